// [design/torque_bias_consts.vh]
`ifndef TORQUE_BIAS_CONSTS_VH
`define TORQUE_BIAS_CONSTS_VH

// register word addresses
`define A_SRC_SEL       4'h0
`define A_STORED_1      4'h1
`define A_STORED_2      4'h2
`define A_STORED_3      4'h3
`define A_RISE_FILTER   4'h4
`define A_HOLD_TIME     4'h5
`define A_BALANCE_V     4'h6
`define A_LOWER_BIAS    4'h7
`define A_LOWER_GAIN    4'h8
`define A_RISE_B_CMD    4'h9
`define A_RISE_B_LVL    4'ha
`define A_RISE_G_CMD    4'hb
`define A_RISE_G_LVL    4'hc
`define A_AIN_FUNC      4'hd
`define A_STATUS        4'he
`define A_BIAS_NOW      4'hf
`define CFG_LAST        4'hd

// values
`define V_UNSET         16'h270f
`define V_STORED_OFS    16'h03e8
`define V_STORED_MIN    16'h0258
`define V_STORED_MAX    16'h0578
`define V_TIME_MAX      16'h1388
`define V_VOLT_MAX      16'h2710
`define V_PCT_MAX       16'h0190
`define V_T1_TORQUE     16'h0006
`define V_RISE_G_CMD    16'h2710
`define V_RISE_G_LVL    16'h0064
`define SEL_CONTACT     16'h0000
`define SEL_T1_REV      16'h0001
`define SEL_T1_FWD      16'h0002
`define SEL_AUTO        16'h0003

// status bit positions
`define ST_B_IDLE       0
`define ST_B_HOLD       1
`define ST_B_RUN        2
`define ST_B_CAL_DONE   3
`define ST_B_T1_TORQUE  4
`define ST_B_MAIN_ZERO  5

// timing: one filter/timer tick per millisecond
`define CLK_PERIOD_NS   25
`define TICK_PERIOD_NS  1000000
`define TICK_CYCLES     (`TICK_PERIOD_NS / `CLK_PERIOD_NS)

`endif

// [design/analog_bias_map.v]
`timescale 1ns/1ps
module analog_bias_map
(
   // analog sample and points, mV and percent
   input  wire        [15:0] i_volt,
   input  wire        [15:0] i_bias_cmd,
   input  wire signed [15:0] i_bias_lvl,
   input  wire        [15:0] i_gain_cmd,
   input  wire signed [15:0] i_gain_lvl,
   // mapped torque bias, percent
   output reg  signed [15:0] o_pct
);
   reg signed [33:0] num;
   reg signed [17:0] den;
   reg signed [17:0] dv;
   reg signed [17:0] dl;
   reg signed [33:0] val;

   always @*
   begin
      num = 34'sd0;
      den = $signed({2'b00, i_gain_cmd}) - $signed({2'b00, i_bias_cmd});
      dv  = $signed({2'b00, i_volt}) - $signed({2'b00, i_bias_cmd});
      dl  = $signed({{2{i_gain_lvl[15]}}, i_gain_lvl})
            - $signed({{2{i_bias_lvl[15]}}, i_bias_lvl});
      val = {{18{i_bias_lvl[15]}}, i_bias_lvl};
      if (den != 18'sd0)
      begin
         num = {{16{dv[17]}}, dv} * {{16{dl[17]}}, dl};
         val = val + num / den;
      end
      if (val > 34'sd400)
         o_pct = 16'sd400;
      else if (val < -34'sd400)
         o_pct = -16'sd400;
      else
         o_pct = val[15:0];
   end
endmodule

// [design/bias_lag_filter.v]
`timescale 1ns/1ps
module bias_lag_filter
(
   // clock, reset, enable
   input  wire               i_clk,
   input  wire               i_rst,
   input  wire               i_ce,
   // control
   input  wire               i_tick,
   input  wire               i_clear,
   input  wire        [15:0] i_tau_ms,
   input  wire signed [15:0] i_target,
   // filtered value
   output wire signed [15:0] o_value
);
   reg  signed [31:0] acc_ff;
   reg  signed [31:0] nxt_acc;
   wire signed [31:0] goal = {i_target, 16'h0000};
   wire signed [32:0] diff = {goal[31], goal} - {acc_ff[31], acc_ff};
   wire signed [32:0] step = diff / $signed({17'h0, i_tau_ms});
   // the lag never overshoots its goal, so the sum always fits 32 bits
   wire signed [32:0] sum  = {acc_ff[31], acc_ff} + step;

   always @*
   begin
      nxt_acc = acc_ff;
      if (i_clear)
         nxt_acc = 32'sd0;
      else if (i_tau_ms == 16'h0000)
         nxt_acc = goal;
      else if (i_tick)
         nxt_acc = sum[31:0];
   end

   always @(posedge i_clk)
   begin
      if (i_rst)
         acc_ff <= 32'sd0;
      else if (i_ce)
         acc_ff <= nxt_acc;
   end

   assign o_value = acc_ff[31:16];
endmodule

// [design/torque_bias_start_assist.v]
`timescale 1ns/1ps
`include "torque_bias_consts.vh"
module torque_bias_start_assist
#(
   parameter TICK_CYCLES = `TICK_CYCLES
)
(
   // clock, reset, enable
   input  wire               I_CLOCK,
   input  wire               I_RST,
   input  wire               I_CE,
   // register port
   input  wire        [3:0]  I_ADDR,
   input  wire        [15:0] I_WDATA,
   input  wire               I_WR,
   input  wire               I_RD,
   output reg         [15:0] O_RDATA,
   // machine side
   input  wire               I_BIAS_SELECT_INPUT_1,
   input  wire               I_BIAS_SELECT_INPUT_2,
   input  wire               I_START,
   input  wire        [15:0] I_ANALOG_MV,
   input  wire               I_ENCODER_OPTION,
   input  wire               I_T1_MAIN_SPEED,
   // drive side
   output reg  signed [15:0] O_TORQUE_BIAS,
   output reg         [15:0] O_TORQUE_REF_PCT,
   output reg                O_BIAS_ACTIVE,
   output reg                O_HOLDING,
   output reg                O_T1_IS_TORQUE,
   output reg                O_MAIN_SPEED_ZERO
);
   localparam ST_IDLE = 3'b001;
   localparam ST_HOLD = 3'b010;
   localparam ST_RUN  = 3'b100;

   reg  [15:0]        cfg_ff [0:13];
   reg  [2:0]         state_ff;
   reg  [2:0]         nxt_state;
   reg  [15:0]        hold_ff;
   reg  [15:0]        nxt_hold;
   reg  [31:0]        tick_cnt_ff;
   reg                tick_ff;
   reg                start_d_ff;
   reg                cal_done_ff;
   reg                wr_ok;
   reg  signed [15:0] target;
   reg  signed [15:0] low_bias;
   reg  signed [15:0] low_gain;
   wire [15:0]        sel = cfg_ff[`A_SRC_SEL];
   wire               start_rise = I_START & ~start_d_ff;
   wire               analog_mode = (sel == `SEL_T1_REV) | (sel == `SEL_T1_FWD);
   wire               bias_on = (sel == `SEL_CONTACT) | analog_mode | (sel == `SEL_AUTO);
   wire signed [15:0] mapped;
   wire signed [15:0] filtered;
   // an unset filter, hold or balance setting behaves as zero
   wire [15:0]        tau = (cfg_ff[`A_RISE_FILTER] == `V_UNSET) ? 16'h0000
                            : cfg_ff[`A_RISE_FILTER];
   wire [15:0]        hold_ms = (cfg_ff[`A_HOLD_TIME] == `V_UNSET) ? 16'h0000
                                : cfg_ff[`A_HOLD_TIME];
   wire [15:0]        balance = (cfg_ff[`A_BALANCE_V] == `V_UNSET) ? 16'h0000
                                : cfg_ff[`A_BALANCE_V];
   wire               rising = I_ANALOG_MV >= balance;
   wire               t1_torque = bias_on & (cfg_ff[`A_AIN_FUNC] == `V_T1_TORQUE);
   wire               main_zero = t1_torque & I_T1_MAIN_SPEED;
   wire [15:0]        status = {10'h000, main_zero, t1_torque, cal_done_ff, state_ff};
   // the lag restarts from zero whenever the start drops or the source is unset
   wire               lag_clear = ~I_START | ~bias_on;

   // stored bias word to signed percent; 9999 or out of range gives none
   function signed [15:0] stored_pct;
      input [15:0] v;
      begin
         if (v >= `V_STORED_MIN && v <= `V_STORED_MAX)
            stored_pct = v - `V_STORED_OFS;
         else
            stored_pct = 16'sd0;
      end
   endfunction

   // value range allowed per register; 9999 always allowed where it has a meaning
   always @*
   begin
      wr_ok = 1'b0;
      case (I_ADDR)
         `A_SRC_SEL:
            wr_ok = (I_WDATA <= `SEL_AUTO) | (I_WDATA == `V_UNSET);
         `A_STORED_1, `A_STORED_2, `A_STORED_3:
            wr_ok = (I_WDATA >= `V_STORED_MIN && I_WDATA <= `V_STORED_MAX)
                    | (I_WDATA == `V_UNSET);
         `A_RISE_FILTER, `A_HOLD_TIME:
            wr_ok = (I_WDATA <= `V_TIME_MAX) | (I_WDATA == `V_UNSET);
         `A_BALANCE_V:
            wr_ok = (I_WDATA <= `V_VOLT_MAX) | (I_WDATA == `V_UNSET);
         `A_LOWER_BIAS, `A_LOWER_GAIN:
            wr_ok = (I_WDATA <= `V_PCT_MAX) | (I_WDATA == `V_UNSET);
         `A_RISE_B_CMD, `A_RISE_G_CMD:
            wr_ok = I_WDATA <= `V_VOLT_MAX;
         `A_RISE_B_LVL, `A_RISE_G_LVL:
            wr_ok = I_WDATA <= `V_PCT_MAX;
         `A_AIN_FUNC:
            wr_ok = 1'b1;
         default:
            wr_ok = 1'b0;
      endcase
      // without the encoder option every write is dropped
      wr_ok = wr_ok & I_ENCODER_OPTION;
   end

   // configuration store; auto-capture shares the write port
   integer i;
   always @(posedge I_CLOCK)
   begin
      if (I_RST)
      begin
         for (i = 0; i <= 13; i = i + 1)
            cfg_ff[i] <= `V_UNSET;
         cfg_ff[`A_RISE_B_CMD] <= 16'h0000;
         cfg_ff[`A_RISE_B_LVL] <= 16'h0000;
         cfg_ff[`A_RISE_G_CMD] <= `V_RISE_G_CMD;
         cfg_ff[`A_RISE_G_LVL] <= `V_RISE_G_LVL;
         cfg_ff[`A_AIN_FUNC]   <= 16'h0000;
         cal_done_ff           <= 1'b0;
      end
      else if (I_CE)
      begin
         if (I_WR && wr_ok)
         begin
            cfg_ff[I_ADDR] <= I_WDATA;
            if (I_ADDR == `A_SRC_SEL)
               cal_done_ff <= 1'b0;
         end
         // a write in the same cycle takes precedence over capture
         else if (sel == `SEL_AUTO && start_rise)
         begin
            cfg_ff[`A_BALANCE_V]  <= I_ANALOG_MV;
            cfg_ff[`A_RISE_B_CMD] <= I_ANALOG_MV;
            cfg_ff[`A_RISE_B_LVL] <= 16'h0000;
            cal_done_ff           <= 1'b1;
         end
      end
   end

   // millisecond tick
   always @(posedge I_CLOCK)
   begin
      if (I_RST)
      begin
         tick_cnt_ff <= 32'h00000000;
         tick_ff     <= 1'b0;
      end
      else if (I_CE)
      begin
         tick_ff <= 1'b0;
         if (tick_cnt_ff >= TICK_CYCLES - 1)
         begin
            tick_cnt_ff <= 32'h00000000;
            tick_ff     <= 1'b1;
         end
         else
            tick_cnt_ff <= tick_cnt_ff + 32'h00000001;
      end
   end

   // lowering points fall back to rise points
   always @*
   begin
      low_bias = (cfg_ff[`A_LOWER_BIAS] == `V_UNSET) ? cfg_ff[`A_RISE_B_LVL]
                 : cfg_ff[`A_LOWER_BIAS];
      low_gain = (cfg_ff[`A_LOWER_GAIN] == `V_UNSET) ? cfg_ff[`A_RISE_G_LVL]
                 : cfg_ff[`A_LOWER_GAIN];
   end

   // below the balance voltage the load is lowering
   wire signed [15:0] bias_lvl = rising ? $signed(cfg_ff[`A_RISE_B_LVL]) : low_bias;
   wire signed [15:0] gain_lvl = rising ? $signed(cfg_ff[`A_RISE_G_LVL]) : low_gain;

   analog_bias_map analog_bias_map_inst
   (
      .i_volt     (I_ANALOG_MV),
      .i_bias_cmd (cfg_ff[`A_RISE_B_CMD]),
      .i_bias_lvl (bias_lvl),
      .i_gain_cmd (cfg_ff[`A_RISE_G_CMD]),
      .i_gain_lvl (gain_lvl),
      .o_pct      (mapped)
   );

   // bias amount by source
   always @*
   begin
      target = 16'sd0;
      case (sel)
         `SEL_CONTACT:
            case ({I_BIAS_SELECT_INPUT_2, I_BIAS_SELECT_INPUT_1})
               2'b01:   target = stored_pct(cfg_ff[`A_STORED_1]);
               2'b10:   target = stored_pct(cfg_ff[`A_STORED_2]);
               2'b11:   target = stored_pct(cfg_ff[`A_STORED_3]);
               default: target = 16'sd0;
            endcase
         `SEL_T1_REV:
            target = -mapped;
         `SEL_T1_FWD:
            target = mapped;
         default:
            target = 16'sd0;
      endcase
      // no bias is built up before the sequence leaves idle
      if (state_ff == ST_IDLE)
         target = 16'sd0;
   end

   bias_lag_filter bias_lag_filter_inst
   (
      .i_clk    (I_CLOCK),
      .i_rst    (I_RST),
      .i_ce     (I_CE),
      .i_tick   (tick_ff),
      .i_clear  (lag_clear),
      .i_tau_ms (tau),
      .i_target (target),
      .o_value  (filtered)
   );

   // start sequence: hold at bias alone, then run
   // hold counts whole ticks; a zero hold leaves one cycle after entry
   always @*
   begin
      nxt_state = state_ff;
      nxt_hold  = hold_ff;
      case (state_ff)
         ST_IDLE:
            if (I_START && bias_on)
            begin
               nxt_state = ST_HOLD;
               nxt_hold  = hold_ms;
            end
         ST_HOLD:
            if (!I_START || !bias_on)
               nxt_state = ST_IDLE;
            else if (hold_ff == 16'h0000)
               nxt_state = ST_RUN;
            else if (tick_ff)
               nxt_hold = hold_ff - 16'h0001;
         ST_RUN:
            if (!I_START || !bias_on)
               nxt_state = ST_IDLE;
         default:
            nxt_state = ST_IDLE;
      endcase
   end

   always @(posedge I_CLOCK)
   begin
      if (I_RST)
      begin
         state_ff          <= ST_IDLE;
         hold_ff           <= 16'h0000;
         start_d_ff        <= 1'b0;
         O_TORQUE_BIAS     <= 16'sd0;
         O_TORQUE_REF_PCT  <= `V_RISE_G_LVL;
         O_BIAS_ACTIVE     <= 1'b0;
         O_HOLDING         <= 1'b0;
      end
      else if (I_CE)
      begin
         state_ff          <= nxt_state;
         hold_ff           <= nxt_hold;
         start_d_ff        <= I_START;
         O_TORQUE_BIAS     <= bias_on ? filtered : 16'sd0;
         O_TORQUE_REF_PCT  <= `V_RISE_G_LVL;
         O_BIAS_ACTIVE     <= bias_on & (nxt_state != ST_IDLE);
         O_HOLDING         <= nxt_state == ST_HOLD;
      end
   end

   // analog input role flags
   always @(posedge I_CLOCK)
   begin
      if (I_RST)
      begin
         O_T1_IS_TORQUE    <= 1'b0;
         O_MAIN_SPEED_ZERO <= 1'b0;
      end
      else if (I_CE)
      begin
         O_T1_IS_TORQUE    <= t1_torque;
         O_MAIN_SPEED_ZERO <= main_zero;
      end
   end

   // register read port; data stand for one cycle, zero otherwise
   always @(posedge I_CLOCK)
   begin
      if (I_RST)
         O_RDATA <= 16'h0000;
      else if (I_CE)
      begin
         O_RDATA <= 16'h0000;
         if (I_RD)
         begin
            if (I_ADDR <= `CFG_LAST)
               O_RDATA <= cfg_ff[I_ADDR];
            else if (I_ADDR == `A_STATUS)
               O_RDATA <= status;
            else
               O_RDATA <= filtered;
         end
      end
   end
endmodule

// [tb/bias_assertions.sv]
`timescale 1ns/1ps
module bias_assertions
(
   // clock, reset, inputs
   input wire               I_CLOCK,
   input wire               I_RST,
   input wire               I_CE,
   input wire               I_START,
   input wire               I_T1_MAIN_SPEED,
   // outputs
   input wire signed [15:0] O_TORQUE_BIAS,
   input wire        [15:0] O_TORQUE_REF_PCT,
   input wire               O_BIAS_ACTIVE,
   input wire               O_HOLDING,
   input wire               O_T1_IS_TORQUE,
   input wire               O_MAIN_SPEED_ZERO
);
   default clocking cb @(posedge I_CLOCK); endclocking
   default disable iff (I_RST);
   chk_ref_rated: assert property (O_TORQUE_REF_PCT == 16'h0064)
      else $error("torque reference left rated value");
   chk_hold_in_run: assert property (O_HOLDING |-> O_BIAS_ACTIVE)
      else $error("holding outside an active start");
   chk_enter_hold: assert property ($rose(O_BIAS_ACTIVE) |-> O_HOLDING)
      else $error("start did not enter hold");
   chk_start_cause: assert property ($rose(O_BIAS_ACTIVE) |-> $past(I_START))
      else $error("bias active without start");
   chk_stop_idles: assert property
      (O_BIAS_ACTIVE && !I_START && I_CE |=> !O_BIAS_ACTIVE && !O_HOLDING)
      else $error("bias stayed active after start fell");
   chk_idle_zero: assert property
      ((!I_START && I_CE) [*3] |=> O_TORQUE_BIAS == 16'sh0000)
      else $error("bias not zero while stopped");
   chk_bias_range: assert property
      (O_TORQUE_BIAS >= -16'sd400 && O_TORQUE_BIAS <= 16'sd400)
      else $error("bias outside 400 percent");
   chk_main_zero: assert property
      ($past(I_CE) |-> O_MAIN_SPEED_ZERO == (O_T1_IS_TORQUE && $past(I_T1_MAIN_SPEED)))
      else $error("main speed zero flag wrong");
endmodule

// [tb/machine_side.sv]
`timescale 1ns/1ps
module machine_side
(
   // commands from the bench
   input  wire        i_clk,
   input  wire [1:0]  i_pick,
   input  wire        i_run,
   input  wire [15:0] i_mv,
   input  wire        i_main,
   // machine pins
   output reg         o_sel_1,
   output reg         o_sel_2,
   output reg         o_start,
   output reg  [15:0] o_mv,
   output reg         o_main
);
   initial {o_sel_1, o_sel_2, o_start, o_mv, o_main} = 20'h0;
   // contacts sit on terminals mapped to codes 42 and 43
   always @(posedge i_clk)
   begin
      o_sel_1 <= i_pick[0];
      o_sel_2 <= i_pick[1];
      o_start <= i_run;
      o_mv    <= i_mv;
      o_main  <= i_main;
   end
endmodule

// [tb/tb.sv]
`timescale 1ns/1ps
`include "torque_bias_consts.vh"
module tb;
   logic               clk, rst, ce, wr, rd, enc, run, main, sel_1, sel_2, start, main_pin;
   logic               active, holding, t1_tq, main_zero;
   logic        [1:0]  pick;
   logic        [3:0]  addr;
   logic        [15:0] wdata, rdata, mv, mv_pin, ref_pct, v;
   logic signed [15:0] bias;
   int                 failures, compares;
   torque_bias_start_assist #(.TICK_CYCLES(4)) torque_bias_start_assist_inst (
      .I_CLOCK(clk), .I_RST(rst), .I_CE(ce), .I_ADDR(addr), .I_WDATA(wdata),
      .I_WR(wr), .I_RD(rd), .O_RDATA(rdata), .I_BIAS_SELECT_INPUT_1(sel_1),
      .I_BIAS_SELECT_INPUT_2(sel_2), .I_START(start), .I_ANALOG_MV(mv_pin),
      .I_ENCODER_OPTION(enc), .I_T1_MAIN_SPEED(main_pin), .O_TORQUE_BIAS(bias),
      .O_TORQUE_REF_PCT(ref_pct), .O_BIAS_ACTIVE(active), .O_HOLDING(holding),
      .O_T1_IS_TORQUE(t1_tq), .O_MAIN_SPEED_ZERO(main_zero));
   machine_side machine_side_inst (.i_clk(clk), .i_pick(pick), .i_run(run), .i_mv(mv),
      .i_main(main), .o_sel_1(sel_1), .o_sel_2(sel_2), .o_start(start), .o_mv(mv_pin),
      .o_main(main_pin));
   task automatic chk(input string name, input logic [15:0] seen, input logic [15:0] exp);
      compares++;
      if (seen !== exp)
      begin
         failures++;
         $display("mismatch %s expected %h seen %h", name, exp, seen);
      end
   endtask
   task automatic wr_reg(input logic [3:0] a, input logic [15:0] d);
      @(posedge clk);
      addr  <= a;
      wdata <= d;
      wr    <= 1'b1;
      @(posedge clk);
      wr <= 1'b0;
   endtask
   task automatic rd_reg(input logic [3:0] a);
      @(posedge clk);
      addr <= a;
      rd   <= 1'b1;
      @(posedge clk);
      rd <= 1'b0;
      #1 v = rdata;
   endtask
   task automatic run_for(input logic [1:0] p, input int n);
      @(posedge clk);
      pick <= p;
      run  <= 1'b1;
      repeat (n) @(posedge clk);
      #1;
   endtask
   task automatic stop;
      @(posedge clk);
      run <= 1'b0;
      repeat (4) @(posedge clk);
   endtask
   task automatic t_defaults;
      logic [15:0] tail [5] = '{16'h0000, 16'h0000, 16'h2710, 16'h0064, 16'h0000};
      for (int i = 0; i < 14; i++)
      begin
         rd_reg(i[3:0]);
         chk("reset value", v, i < 9 ? `V_UNSET : tail[i-9]);
      end
      rd_reg(`A_STATUS);
      chk("status idle", v, 16'h0001);
      @(posedge clk);
      #1 chk("read data cleared", rdata, 16'h0000);
      $display("test defaults done");
   endtask
   task automatic t_refuse;
      @(posedge clk);
      enc <= 1'b0;
      wr_reg(`A_STORED_1, 16'h0400);
      @(posedge clk);
      enc <= 1'b1;
      rd_reg(`A_STORED_1);
      chk("no encoder write", v, `V_UNSET);
      wr_reg(`A_STORED_1, 16'h0579);
      wr_reg(`A_STORED_1, 16'h0257);
      rd_reg(`A_STORED_1);
      chk("stored out of range", v, `V_UNSET);
      wr_reg(`A_STORED_1, 16'h0258);
      rd_reg(`A_STORED_1);
      chk("stored lower bound", v, 16'h0258);
      wr_reg(`A_STATUS, 16'h00ff);
      rd_reg(`A_STATUS);
      chk("status read only", v, 16'h0001);
      $display("test refuse done");
   endtask
   task automatic t_contact;
      logic [15:0] exp [4] = '{16'h0000, 16'h0019, 16'hffe7, 16'hffb5};
      wr_reg(`A_SRC_SEL, `SEL_CONTACT);
      wr_reg(`A_STORED_1, 16'h0401);
      wr_reg(`A_STORED_2, 16'h03cf);
      wr_reg(`A_STORED_3, 16'h039d);
      for (int p = 0; p < 4; p++)
      begin
         run_for(p[1:0], 8);
         chk("contact bias", bias, exp[p]);
         chk("active", {15'h0, active}, 16'h0001);
         chk("no hold", {15'h0, holding}, 16'h0000);
         stop;
      end
      $display("test contact done");
   endtask
   task automatic t_freeze;
      run_for(2'b01, 8);
      rd_reg(`A_BIAS_NOW);
      chk("bias register", v, 16'h0019);
      @(posedge clk);
      ce   <= 1'b0;
      pick <= 2'b11;
      repeat (8) @(posedge clk);
      #1 chk("frozen bias", bias, 16'h0019);
      chk("rated ref", ref_pct, 16'h0064);
      @(posedge clk);
      ce <= 1'b1;
      repeat (4) @(posedge clk);
      #1 chk("thawed bias", bias, 16'hffb5);
      stop;
      $display("test freeze done");
   endtask
   task automatic t_hold_filter;
      wr_reg(`A_HOLD_TIME, 16'h0005);
      run_for(2'b01, 10);
      chk("holding", {15'h0, holding}, 16'h0001);
      repeat (30) @(posedge clk);
      #1 chk("hold ended", {15'h0, holding}, 16'h0000);
      stop;
      wr_reg(`A_HOLD_TIME, 16'h0000);
      wr_reg(`A_RISE_FILTER, 16'h000a);
      run_for(2'b01, 8);
      chk("bias rising", {15'h0, bias > 0 && bias < 25}, 16'h0001);
      repeat (600) @(posedge clk);
      #1 chk("bias settled", {15'h0, bias >= 24}, 16'h0001);
      stop;
      wr_reg(`A_RISE_FILTER, `V_UNSET);
      $display("test hold filter done");
   endtask
   task automatic t_unset;
      wr_reg(`A_STORED_1, `V_UNSET);
      run_for(2'b01, 8);
      chk("unset stored", bias, 16'h0000);
      stop;
      wr_reg(`A_SRC_SEL, `V_UNSET);
      run_for(2'b11, 8);
      chk("no bias", bias, 16'h0000);
      chk("not active", {15'h0, active}, 16'h0000);
      stop;
      $display("test unset done");
   endtask
   task automatic t_analog;
      wr_reg(`A_AIN_FUNC, `V_T1_TORQUE);
      wr_reg(`A_SRC_SEL, `SEL_T1_FWD);
      @(posedge clk);
      mv   <= 16'h1388;
      main <= 1'b1;
      run_for(2'b00, 8);
      chk("forward analog", bias, 16'h0032);
      chk("t1 torque", {15'h0, t1_tq}, 16'h0001);
      chk("main zero", {15'h0, main_zero}, 16'h0001);
      stop;
      wr_reg(`A_SRC_SEL, `SEL_T1_REV);
      run_for(2'b00, 8);
      chk("reverse analog", bias, 16'hffce);
      stop;
      wr_reg(`A_SRC_SEL, `SEL_T1_FWD);
      wr_reg(`A_BALANCE_V, 16'h1770);
      wr_reg(`A_LOWER_GAIN, 16'h00c8);
      run_for(2'b00, 8);
      chk("lowering gain", bias, 16'h0064);
      stop;
      wr_reg(`A_LOWER_BIAS, 16'h0014);
      run_for(2'b00, 8);
      chk("lowering bias", bias, 16'h006e);
      stop;
      $display("test analog done");
   endtask
   task automatic t_auto;
      wr_reg(`A_SRC_SEL, `SEL_AUTO);
      @(posedge clk);
      mv <= 16'h0bb8;
      run_for(2'b00, 6);
      chk("auto no bias", bias, 16'h0000);
      stop;
      rd_reg(`A_BALANCE_V);
      chk("captured balance", v, 16'h0bb8);
      rd_reg(`A_RISE_B_CMD);
      chk("captured bias cmd", v, 16'h0bb8);
      rd_reg(`A_STATUS);
      chk("cal done", {15'h0, v[`ST_B_CAL_DONE]}, 16'h0001);
      wr_reg(`A_SRC_SEL, `SEL_T1_FWD);
      rd_reg(`A_STATUS);
      chk("cal cleared", {15'h0, v[`ST_B_CAL_DONE]}, 16'h0000);
      $display("test auto done");
   endtask
   task automatic complete_run;
      $display("compares %0d failures %0d", compares, failures);
      if (failures == 0 && compares > 0)
         $display("DONE - PASS");
      else
         $display("DONE - FAIL");
      $finish;
   endtask
   initial
   begin
      clk = 1'b0;
      forever #12.5 clk = ~clk;
   end
   initial
   begin
      #2000000;
      failures++;
      $display("mismatch watchdog expected end seen hang");
      complete_run;
   end
   initial
   begin
      {rst, ce, enc, wr, rd, run, main, pick, addr, wdata, mv} = '0;
      rst = 1'b1;
      ce  = 1'b1;
      enc = 1'b1;
      repeat (2) @(posedge clk);
      rst <= 1'b0;
      t_defaults;
      t_refuse;
      t_contact;
      t_freeze;
      t_hold_filter;
      t_unset;
      t_analog;
      t_auto;
      complete_run;
   end
endmodule
bind torque_bias_start_assist bias_assertions bias_assertions_inst (.I_CLOCK(I_CLOCK),
   .I_RST(I_RST), .I_CE(I_CE), .I_START(I_START), .I_T1_MAIN_SPEED(I_T1_MAIN_SPEED),
   .O_TORQUE_BIAS(O_TORQUE_BIAS), .O_TORQUE_REF_PCT(O_TORQUE_REF_PCT),
   .O_BIAS_ACTIVE(O_BIAS_ACTIVE), .O_HOLDING(O_HOLDING), .O_T1_IS_TORQUE(O_T1_IS_TORQUE),
   .O_MAIN_SPEED_ZERO(O_MAIN_SPEED_ZERO));
